// ### design/ucrb_map.vh
// Register map, field positions, reset values and timing counts of the receive buffer block
`ifndef UCRB_MAP_VH
`define UCRB_MAP_VH

`define UCRB_ADDR_W          8
`define UCRB_OFF_STATUS      8'h00
`define UCRB_OFF_CTRL_B      8'h04
`define UCRB_OFF_CTRL_C      8'h08
`define UCRB_OFF_DATA        8'h0c
`define UCRB_OFF_BAUD        8'h10

`define UCRB_ST_RXC          7
`define UCRB_ST_FE           4
`define UCRB_ST_DOR          3
`define UCRB_ST_PE           2

`define UCRB_CB_IRQ_EN       7
`define UCRB_CB_RX_EN        4
`define UCRB_CB_SIZE2        2
`define UCRB_CB_RX9          1
`define UCRB_CB_TX9          0

`define UCRB_CC_PAR_EN       5
`define UCRB_CC_PAR_ODD      4
`define UCRB_CC_STOP2        3
`define UCRB_CC_SIZE_HI      2
`define UCRB_CC_SIZE_LO      1

`define UCRB_SIZE_NINE       3'h7
`define UCRB_CTRL_C_RST      8'h06
`define UCRB_CTRL_B_RST      8'h00
`define UCRB_BAUD_W          12
`define UCRB_BAUD_RST        12'h01a

`define UCRB_OVS_MID         4'h7
`define UCRB_OVS_LAST        4'hf

`define UCRB_ENT_W           12
`define UCRB_ENT_FE          9
`define UCRB_ENT_DOR         10
`define UCRB_ENT_PE          11

`endif

// ### design/ucrb_fifo.v
// Two-entry receive FIFO holding data, ninth bit and error flags of each frame
`timescale 1ns/10ps
`include "ucrb_map.vh"

module ucrb_fifo (
    input  wire                   clk,
    input  wire                   arst_n,
    input  wire                   flush,
    input  wire                   push,
    input  wire [`UCRB_ENT_W-1:0] pushData,
    input  wire                   pop,
    output wire [`UCRB_ENT_W-1:0] headData,
    output wire                   notEmpty,
    output wire                   full
);
    reg [`UCRB_ENT_W-1:0] ent0_ff;
    reg [`UCRB_ENT_W-1:0] ent1_ff;
    reg                   wrPtr_ff;
    reg                   rdPtr_ff;
    reg [1:0]             count_ff;
    wire                  doPush;
    wire                  doPop;

    assign full     = (count_ff == 2'h2);
    assign notEmpty = (count_ff != 2'h0);
    assign doPush   = push && !full;
    assign doPop    = pop && notEmpty;
    // Empty FIFO reads as zero so stale flags never show
    assign headData = !notEmpty ? {`UCRB_ENT_W{1'b0}} : (rdPtr_ff ? ent1_ff : ent0_ff);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ent0_ff  <= {`UCRB_ENT_W{1'b0}};
            ent1_ff  <= {`UCRB_ENT_W{1'b0}};
            wrPtr_ff <= 1'b0;
            rdPtr_ff <= 1'b0;
            count_ff <= 2'h0;
        end else if (flush) begin
            wrPtr_ff <= 1'b0;
            rdPtr_ff <= 1'b0;
            count_ff <= 2'h0;
        end else begin
            if (doPush) begin
                if (wrPtr_ff) begin
                    ent1_ff <= pushData;
                end else begin
                    ent0_ff <= pushData;
                end
                wrPtr_ff <= ~wrPtr_ff;
            end
            if (doPop) begin
                rdPtr_ff <= ~rdPtr_ff;
            end
            if (doPush && !doPop) begin
                count_ff <= count_ff + 2'h1;
            end else if (doPop && !doPush) begin
                count_ff <= count_ff - 2'h1;
            end
        end
    end
endmodule

// ### design/ucrb_rx.v
// Serial receiver with two-entry buffer, error flags, parity check and APB register slave
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/10ps
`include "ucrb_map.vh"

module ucrb_rx (
    input  wire                    clk,
    input  wire                    arst_n,
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [`UCRB_ADDR_W-1:0] paddr,
    input  wire [31:0]             pwdata,
    output reg  [31:0]             prdata,
    output wire                    pready,
    output wire                    pslverr,
    input  wire                    rxd,
    input  wire                    globalIrqEn,
    output wire                    rxIrqReq,
    output wire                    rxPinOwned
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_START = 3'h1;
    localparam ST_DATA  = 3'h2;
    localparam ST_PAR   = 3'h3;
    localparam ST_STOP  = 3'h4;

    reg  [7:0]              ctrlB_ff;
    reg  [7:0]              ctrlC_ff;
    reg  [`UCRB_BAUD_W-1:0] baud_ff;
    reg  [`UCRB_BAUD_W-1:0] divCnt_ff;
    reg  [3:0]              ovsCnt_ff;
    reg  [2:0]              state_ff;
    reg  [2:0]              nxt_state;
    reg  [3:0]              bitCnt_ff;
    reg  [8:0]              dataSh_ff;
    reg                     parBit_ff;
    reg                     rxdPrev_ff;
    reg  [`UCRB_ENT_W-1:0]  hold_ff;
    reg                     holdValid_ff;
    reg                     dorPend_ff;
    reg                     rdErr_ff;
    reg                     rdPop_ff;
    reg  [31:0]             nxt_prdata;

    wire                    rx_enable_bit;
    wire                    irqEn;
    wire                    parEn;
    wire                    parOdd;
    wire [2:0]              charSize;
    wire [3:0]              nBits;
    wire                    tick;
    wire                    startEdge;
    wire                    frameDone;
    wire                    peCalc;
    wire [`UCRB_ENT_W-1:0]  frameWord;
    wire                    fifoFull;
    wire                    fifoNotEmpty;
    wire [`UCRB_ENT_W-1:0]  head;
    wire                    pushNow;
    wire [`UCRB_ENT_W-1:0]  pushWord;
    wire                    setupPhase;
    wire                    accessPhase;
    wire                    wrAccess;
    wire                    popNow;
    wire                    mapped;
    wire                    lostStart;
    wire                    rxOff;

    assign rx_enable_bit     = ctrlB_ff[`UCRB_CB_RX_EN];
    assign irqEn    = ctrlB_ff[`UCRB_CB_IRQ_EN];
    assign parEn    = ctrlC_ff[`UCRB_CC_PAR_EN];
    assign parOdd   = ctrlC_ff[`UCRB_CC_PAR_ODD];
    assign charSize = {ctrlB_ff[`UCRB_CB_SIZE2], ctrlC_ff[`UCRB_CC_SIZE_HI], ctrlC_ff[`UCRB_CC_SIZE_LO]};
    // Codes 4..6 are reserved; treated as eight bits
    assign nBits    = (charSize == `UCRB_SIZE_NINE) ? 4'h9 :
                      charSize[2] ? 4'h8 : {2'b01, charSize[1:0]} + 4'h1;

    assign rxPinOwned = rx_enable_bit;
    assign rxIrqReq   = irqEn && globalIrqEn && fifoNotEmpty;

    // Oversampling enable at sixteen times the bit rate
    assign tick = (divCnt_ff == baud_ff);
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            divCnt_ff <= {`UCRB_BAUD_W{1'b0}};
        end else if (tick || !rx_enable_bit) begin
            divCnt_ff <= {`UCRB_BAUD_W{1'b0}};
        end else begin
            divCnt_ff <= divCnt_ff + {{(`UCRB_BAUD_W-1){1'b0}}, 1'b1};
        end
    end

    assign startEdge = rxdPrev_ff && !rxd && (state_ff == ST_IDLE);
    // A waiting frame with a full FIFO cannot make room, so the new frame is lost
    assign lostStart = startEdge && holdValid_ff && fifoFull;
    assign frameDone = (state_ff == ST_STOP) && tick && (ovsCnt_ff == `UCRB_OVS_LAST);
    assign peCalc    = parEn && ((^dataSh_ff) ^ parBit_ff ^ parOdd);
    // Stop bit sampled as zero marks a framing error
    assign frameWord = {peCalc, dorPend_ff, ~rxd, dataSh_ff};

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (startEdge && !lostStart) begin
                    nxt_state = ST_START;
                end
            end
            ST_START: begin
                if (tick && ovsCnt_ff == `UCRB_OVS_MID) begin
                    nxt_state = rxd ? ST_IDLE : ST_DATA;
                end
            end
            ST_DATA: begin
                if (tick && ovsCnt_ff == `UCRB_OVS_LAST && bitCnt_ff == nBits - 4'h1) begin
                    nxt_state = parEn ? ST_PAR : ST_STOP;
                end
            end
            ST_PAR: begin
                if (tick && ovsCnt_ff == `UCRB_OVS_LAST) begin
                    nxt_state = ST_STOP;
                end
            end
            ST_STOP: begin
                // Back to idle at the middle of the first stop bit, once it is sampled
                if (frameDone) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff   <= ST_IDLE;
            ovsCnt_ff  <= 4'h0;
            bitCnt_ff  <= 4'h0;
            dataSh_ff  <= 9'h000;
            parBit_ff  <= 1'b0;
            rxdPrev_ff <= 1'b1;
        end else if (!rx_enable_bit) begin
            state_ff   <= ST_IDLE;
            ovsCnt_ff  <= 4'h0;
            bitCnt_ff  <= 4'h0;
            rxdPrev_ff <= 1'b1;
        end else begin
            state_ff   <= nxt_state;
            rxdPrev_ff <= rxd;
            if (state_ff == ST_IDLE) begin
                ovsCnt_ff <= 4'h0;
                bitCnt_ff <= 4'h0;
                if (startEdge) begin
                    dataSh_ff <= 9'h000;
                    parBit_ff <= 1'b0;
                end
            end else if (tick) begin
                if (state_ff == ST_START && ovsCnt_ff == `UCRB_OVS_MID) begin
                    ovsCnt_ff <= 4'h0;
                end else begin
                    ovsCnt_ff <= ovsCnt_ff + 4'h1;
                end
                if (ovsCnt_ff == `UCRB_OVS_LAST) begin
                    if (state_ff == ST_DATA) begin
                        dataSh_ff[bitCnt_ff] <= rxd;
                        bitCnt_ff <= bitCnt_ff + 4'h1;
                    end
                    if (state_ff == ST_PAR) begin
                        parBit_ff <= rxd;
                    end
                end
            end
        end
    end

    // A waiting frame goes first; a new frame only pushes directly when nothing waits
    assign pushNow  = rx_enable_bit && ((holdValid_ff && !fifoFull) || (frameDone && !holdValid_ff && !fifoFull));
    assign pushWord = holdValid_ff ? hold_ff : frameWord;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_ff      <= {`UCRB_ENT_W{1'b0}};
            holdValid_ff <= 1'b0;
            dorPend_ff   <= 1'b0;
        end else if (!rx_enable_bit) begin
            holdValid_ff <= 1'b0;
            dorPend_ff   <= 1'b0;
        end else begin
            if (frameDone && (holdValid_ff || fifoFull)) begin
                hold_ff      <= frameWord;
                holdValid_ff <= 1'b1;
            end else if (holdValid_ff && !fifoFull) begin
                holdValid_ff <= 1'b0;
            end
            if (lostStart) begin
                dorPend_ff <= 1'b1;
            end else if (pushNow && !holdValid_ff) begin
                dorPend_ff <= 1'b0;
            end
        end
    end

    // Flush on the disabling write itself, so the flag and request drop at once
    assign rxOff = !rx_enable_bit || (wrAccess && (paddr == `UCRB_OFF_CTRL_B) && !pwdata[`UCRB_CB_RX_EN]);

    ucrb_fifo u_fifo (
        .clk      (clk),
        .arst_n   (arst_n),
        .flush    (rxOff),
        .push     (pushNow),
        .pushData (pushWord),
        .pop      (popNow),
        .headData (head),
        .notEmpty (fifoNotEmpty),
        .full     (fifoFull)
    );

    // APB: read data captured in setup, pop only if data existed then
    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    assign wrAccess    = accessPhase && pwrite && !rdErr_ff;
    assign popNow      = accessPhase && rdPop_ff;
    assign pready      = 1'b1;
    assign pslverr     = accessPhase && rdErr_ff;
    assign mapped      = (paddr == `UCRB_OFF_STATUS) || (paddr == `UCRB_OFF_CTRL_B) ||
                         (paddr == `UCRB_OFF_CTRL_C) || (paddr == `UCRB_OFF_DATA) ||
                         (paddr == `UCRB_OFF_BAUD);

    always @* begin
        nxt_prdata = 32'h0000_0000;
        case (paddr)
            `UCRB_OFF_STATUS: begin
                nxt_prdata[`UCRB_ST_RXC] = fifoNotEmpty;
                nxt_prdata[`UCRB_ST_FE]  = head[`UCRB_ENT_FE];
                nxt_prdata[`UCRB_ST_DOR] = head[`UCRB_ENT_DOR];
                nxt_prdata[`UCRB_ST_PE]  = head[`UCRB_ENT_PE];
            end
            `UCRB_OFF_CTRL_B: begin
                nxt_prdata[7:0] = ctrlB_ff;
                nxt_prdata[`UCRB_CB_RX9] = (charSize == `UCRB_SIZE_NINE) && head[8];
            end
            `UCRB_OFF_CTRL_C: begin
                nxt_prdata[7:0] = ctrlC_ff;
            end
            `UCRB_OFF_DATA: begin
                nxt_prdata[7:0] = head[7:0];
            end
            `UCRB_OFF_BAUD: begin
                nxt_prdata[`UCRB_BAUD_W-1:0] = baud_ff;
            end
            default: begin
                nxt_prdata = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata   <= 32'h0000_0000;
            rdErr_ff <= 1'b0;
            rdPop_ff <= 1'b0;
        end else if (setupPhase) begin
            prdata   <= nxt_prdata;
            rdErr_ff <= !mapped;
            rdPop_ff <= !pwrite && (paddr == `UCRB_OFF_DATA) && fifoNotEmpty;
        end else if (accessPhase) begin
            rdPop_ff <= 1'b0;
        end
    end

    // Status register holds no writable field, so flag writes have no effect
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrlB_ff <= `UCRB_CTRL_B_RST;
            ctrlC_ff <= `UCRB_CTRL_C_RST;
            baud_ff  <= `UCRB_BAUD_RST;
        end else if (wrAccess) begin
            case (paddr)
                `UCRB_OFF_CTRL_B: begin
                    ctrlB_ff <= {pwdata[7:2], 1'b0, pwdata[0]};
                end
                `UCRB_OFF_CTRL_C: begin
                    ctrlC_ff <= pwdata[7:0];
                end
                `UCRB_OFF_BAUD: begin
                    baud_ff <= pwdata[`UCRB_BAUD_W-1:0];
                end
                default: begin
                    ctrlB_ff <= ctrlB_ff;
                end
            endcase
        end
    end
endmodule

// ### testbench/ucrb_rx_assertions.sv
// Port-level checks of the receive buffer block
`timescale 1ns/10ps
`include "ucrb_map.vh"

module ucrb_rx_assertions (
    input wire logic                    clk,
    input wire logic                    arst_n,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [`UCRB_ADDR_W-1:0] paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic                    rxd,
    input wire logic                    globalIrqEn,
    input wire logic                    rxIrqReq,
    input wire logic                    rxPinOwned
);
    wire acc = psel && penable;
    wire ctlWr = acc && pwrite && (paddr == `UCRB_OFF_CTRL_B);
    wire stSetup = psel && !penable && !pwrite && (paddr == `UCRB_OFF_STATUS);
    wire mapped = (paddr == `UCRB_OFF_STATUS) || (paddr == `UCRB_OFF_CTRL_B) || (paddr == `UCRB_OFF_CTRL_C)
                  || (paddr == `UCRB_OFF_DATA) || (paddr == `UCRB_OFF_BAUD);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_ready_high; pready; endproperty
    a_ready_high: assert property (p_ready_high) else $error("pready low");
    property p_err_map; acc |-> (pslverr == !mapped); endproperty
    a_err_map: assert property (p_err_map) else $error("pslverr disagrees with address map");
    property p_err_idle; pslverr |-> acc; endproperty
    a_err_idle: assert property (p_err_idle) else $error("pslverr outside access phase");
    property p_rdata_hold; acc |=> $stable(prdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("prdata moved during access");
    property p_pin_follow; ctlWr |=> (rxPinOwned == $past(pwdata[4])); endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("pin ownership ignores enable");
    property p_pin_steady; $changed(rxPinOwned) |-> $past(ctlWr); endproperty
    a_pin_steady: assert property (p_pin_steady) else $error("pin ownership moved alone");
    property p_flush_irq; ctlWr && !pwdata[4] |=> !rxIrqReq [*3]; endproperty
    a_flush_irq: assert property (p_flush_irq) else $error("request after disable");
    property p_irq_gate; rxIrqReq |-> globalIrqEn && rxPinOwned; endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request without enables");
    property p_rxc_seen; stSetup && rxIrqReq |=> prdata[7]; endproperty
    a_rxc_seen: assert property (p_rxc_seen) else $error("flag low while request high");
    property p_off_empty; stSetup && !rxPinOwned |=> (prdata == 32'h0); endproperty
    a_off_empty: assert property (p_off_empty) else $error("status set while disabled");
    property p_reset_quiet; $rose(arst_n) |-> !rxIrqReq && !rxPinOwned && (prdata == 32'h0); endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");

    c_irq: cover property (rxIrqReq);
    c_err: cover property (acc && pslverr);
    c_rxc: cover property (stSetup && rxIrqReq);
endmodule

bind ucrb_rx ucrb_rx_assertions u_chk (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .globalIrqEn(globalIrqEn), .rxIrqReq(rxIrqReq), .rxPinOwned(rxPinOwned)
);

// ### testbench/ucrb_tx_model.sv
// Remote serial transmitter driving the receive line
`timescale 1ns/10ps

module ucrb_tx_model #(
    parameter int BIT_CYC = 16
) (
    input  wire logic clk,
    output logic      rxd
);
    // Idle line rests high between frames
    initial rxd = 1'b1;

    // Sends only the first stop bit; a second one would be ignored anyway
    task automatic send(input logic [11:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rxd <= bits[i];
            repeat (BIT_CYC - 1) @(posedge clk);
        end
        @(posedge clk);
        rxd <= 1'b1;
    endtask
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the receive buffer block with a queue model of its entries
`timescale 1ns/10ps
`include "ucrb_map.vh"

module testbench;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        globalIrqEn = 1'b0;
    wire  [31:0] prdata;
    wire         pready, pslverr, rxd, rxIrqReq, rxPinOwned;
    int          mismatches = 0;
    int          checked = 0;
    int          nb, n;
    logic [31:0] seed = 32'h000172a9;
    logic [31:0] rd, r, cb, last;
    logic        lastErr, nine, pen, odd;
    logic [2:0]  sz;
    logic [11:0] q[$];

    always #10 clk = ~clk;

    ucrb_rx dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
        .globalIrqEn(globalIrqEn), .rxIrqReq(rxIrqReq), .rxPinOwned(rxPinOwned));
    ucrb_tx_model #(.BIT_CYC(16)) tx (.clk(clk), .rxd(rxd));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Model entry: [8:0] data, [9] frame error, [10] overrun, [11] parity error
    task automatic frame(input logic [8:0] d, input int nbits, input logic pe, input logic od,
                         input logic bad, input logic stp);
        logic [11:0] f;
        logic [8:0]  m;
        int          pos;
        m = d & ((9'h001 << nbits) - 9'h001);
        f = {2'h0, m, 1'b0};
        pos = nbits + 1;
        if (pe) begin
            f[pos] = ^m ^ od ^ bad;
            pos++;
        end
        f[pos] = stp;
        tx.send(f, pos + 1);
        q.push_back({pe & bad, 1'b0, ~stp, m});
    endtask

    task automatic rd_entry(input logic nn, input logic [31:0] cbv);
        logic [11:0] e;
        e = q.pop_front();
        apb(1'b0, `UCRB_OFF_STATUS, 32'h0);
        chk(rd, {24'h0, 1'b1, 2'b0, e[9], e[10], e[11], 2'b0});
        apb(1'b0, `UCRB_OFF_CTRL_B, 32'h0);
        chk(rd, cbv | {30'h0, nn & e[8], 1'b0});
        apb(1'b0, `UCRB_OFF_DATA, 32'h0);
        chk(rd, {24'h0, e[7:0]});
    endtask

    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        apb(1'b0, `UCRB_OFF_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `UCRB_OFF_CTRL_C, 32'h0);
        chk(rd, {24'h0, `UCRB_CTRL_C_RST});
        apb(1'b0, `UCRB_OFF_BAUD, 32'h0);
        chk(rd, {20'h0, `UCRB_BAUD_RST});
        apb(1'b0, `UCRB_OFF_DATA, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 8'h14, 32'h0000ffff);
        chk({31'h0, lastErr}, 32'h1);
        apb(1'b1, `UCRB_OFF_BAUD, 32'h0);
        // Size codes 0 to 3 and 7 against off, even and odd parity
        for (int i = 0; i < 15; i++) begin
            sz = (i % 5 == 4) ? `UCRB_SIZE_NINE : 3'(i % 5);
            nine = (sz == `UCRB_SIZE_NINE);
            nb = nine ? 9 : 5 + int'(sz);
            pen = ((i / 5) != 0);
            odd = ((i / 5) == 2);
            r = rnd();
            apb(1'b1, `UCRB_OFF_CTRL_C, {26'h0, pen, odd, r[20], sz[1:0], 1'b0});
            cb = 32'h00000090 | {29'h0, sz[2], 2'b0};
            apb(1'b1, `UCRB_OFF_CTRL_B, cb);
            globalIrqEn <= r[21];
            frame(r[8:0], nb, pen, odd, r[9], ~(r[10] & r[11]));
            frame(r[18:10], nb, pen, odd, r[19], 1'b1);
            // Error flag positions (FE, DOR, PE) go out as zero, as software must write them
            apb(1'b1, `UCRB_OFF_STATUS, {24'h0, r[29:22] & 8'he3});
            chk({31'h0, rxIrqReq}, {31'h0, r[21]});
            rd_entry(nine, cb);
            rd_entry(nine, cb);
            @(posedge clk);
            chk({31'h0, rxIrqReq}, 32'h0);
        end
        // Four frames: two fill the entries, one waits in the hold register, the fourth is lost
        apb(1'b1, `UCRB_OFF_CTRL_C, 32'h00000006);
        apb(1'b1, `UCRB_OFF_CTRL_B, 32'h00000090);
        frame(9'h0a5, 8, 1'b0, 1'b0, 1'b0, 1'b1);
        frame(9'h03c, 8, 1'b0, 1'b0, 1'b0, 1'b1);
        frame(9'h0ff, 8, 1'b0, 1'b0, 1'b0, 1'b1);
        frame(9'h000, 8, 1'b0, 1'b0, 1'b0, 1'b1);
        rd_entry(1'b0, 32'h00000090);
        rd_entry(1'b0, 32'h00000090);
        q.delete();
        r = rnd();
        frame(r[8:0], 8, 1'b0, 1'b0, 1'b0, 1'b1);
        apb(1'b0, `UCRB_OFF_STATUS, 32'h0);
        // Head is the frame that waited in the hold register; the next frame behind it carries the overrun flag of the lost one
        chk({31'h0, rd[3]}, 32'h0);
        n = 0;
        while (rd[7] === 1'b1 && n < 3) begin
            apb(1'b0, `UCRB_OFF_DATA, 32'h0);
            last = rd;
            apb(1'b0, `UCRB_OFF_STATUS, 32'h0);
            if (rd[7] === 1'b1) chk({31'h0, rd[3]}, 32'h1);
            n++;
        end
        chk(last, {24'h0, r[7:0]});
        chk(rd, 32'h0);
        // Full buffer, then disable in mid-frame
        frame(r[16:8], 8, 1'b0, 1'b0, 1'b0, 1'b1);
        apb(1'b0, `UCRB_OFF_STATUS, 32'h0);
        chk(rd, 32'h00000080);
        frame(r[24:16], 8, 1'b0, 1'b0, 1'b0, 1'b1);
        fork
            frame(9'h055, 8, 1'b0, 1'b0, 1'b0, 1'b1);
            begin
                repeat (60) @(posedge clk);
                apb(1'b1, `UCRB_OFF_CTRL_B, 32'h00000080);
            end
        join
        chk({30'h0, rxIrqReq, rxPinOwned}, 32'h0);
        apb(1'b0, `UCRB_OFF_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `UCRB_OFF_CTRL_B, 32'h00000090);
        apb(1'b0, `UCRB_OFF_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `UCRB_OFF_DATA, 32'h0);
        chk(rd, 32'h0);
        final_report();
    end

    initial begin
        repeat (50000) @(posedge clk);
        mismatches++;
        final_report();
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
endmodule
